// [bench/core_model.sv]
// processor core model: takes each presented vector, promptly or after three cycles
// assumes core_req is registered on pclk and an ack is only given while it is valid
module core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // unit side
  input wire irq_vec_pkg::vec_req_t core_req,
  input wire logic slow,
  output logic vector_ack,
  output logic [15:0] last_addr,
  output logic [7:0] ack_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;
  // ack only while a vector is shown, so the address logged is the one taken
  assign vector_ack = core_req.valid && (!slow || wait_q == 2'h3);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 2'h0;
      last_addr <= 16'h0000;
      ack_count <= 8'h00;
    end else if (vector_ack) begin
      wait_q <= 2'h0;
      last_addr <= core_req.addr;
      ack_count <= ack_count + 8'h01;
    end else begin
      wait_q <= core_req.valid ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule

// [bench/external_irq_and_vector_unit_tb.sv]
// self-checking bench of the interrupt and vector unit
// assumes core_model, the unit's package and its header
`include "irq_vec_params.svh"
module external_irq_and_vector_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_irq_pin = 1'b1;
  logic [3:0] pin_change_inputs = 4'h0;
  logic [7:0] other_irq_req = 8'h00;
  logic global_irq_enable = 1'b0;
  logic slow = 1'b0;
  logic vector_ack;
  irq_vec_pkg::vec_req_t core_req;
  logic boot_fetch;
  logic wake_req;
  logic irq;
  logic [15:0] last_addr;
  logic [7:0] ack_count;
  logic [31:0] rd;
  logic err;
  int err_count = 0;
  int comparisons = 0;
  logic [7:0] offs [6] = '{`OFF_SENSE, `OFF_EXT_EN, `OFF_EXT_FLAGS, `OFF_PC_CTRL, `OFF_PC_FLAGS, `OFF_PC_MASK};
  logic [31:0] wmax [6] = '{32'h3, 32'h1, 32'h0, 32'h1, 32'h0, 32'hf};

  always #4 pclk = ~pclk;

  external_irq_and_vector_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin(ext_irq_pin), .pin_change_inputs(pin_change_inputs), .other_irq_req(other_irq_req),
    .global_irq_enable(global_irq_enable), .vector_ack(vector_ack), .core_req(core_req),
    .boot_fetch(boot_fetch), .wake_req(wake_req), .irq(irq));
  core_model core (.pclk(pclk), .presetn(presetn), .core_req(core_req), .slow(slow),
    .vector_ack(vector_ack), .last_addr(last_addr), .ack_count(ack_count));

  task automatic tally_and_finish();
    $display("counts: %0d checks, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic wait_ack(input logic [15:0] exp);
    logic [7:0] c;
    int n;
    c = ack_count;
    n = 0;
    while (ack_count === c && n < 60) begin
      @(posedge pclk);
      n++;
    end
    if (ack_count === c) begin
      err_count++;
      tally_and_finish();
    end
    chk("vector", {16'h0, exp}, {16'h0, last_addr});
  endtask

  initial begin
    tick(2);
    chk("boot fetch", 32'h1, {31'h0, boot_fetch});
    chk("reset vector", 32'h0, {16'h0, core_req.addr});
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i]) begin
      rdchk(offs[i], 32'h0, "reset value");
      wr(offs[i], 32'hffffffff);
      rdchk(offs[i], wmax[i], "writable bits");
      wr(offs[i], 32'h0);
    end
    rdchk(8'h20, 32'h0, "unmapped read");
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      wr(`OFF_SENSE, 32'(m));
      wr(`OFF_EXT_FLAGS, 32'h1);
      ext_irq_pin <= 1'b0;
      tick(4);
      rdchk(`OFF_EXT_FLAGS, 32'(m == 1 || m == 2), "fall flag");
      wr(`OFF_EXT_FLAGS, 32'h1);
      ext_irq_pin <= 1'b1;
      tick(4);
      rdchk(`OFF_EXT_FLAGS, 32'(m == 1 || m == 3), "rise flag");
    end
    wr(`OFF_EXT_FLAGS, 32'h1);
    rdchk(`OFF_EXT_FLAGS, 32'h0, "flag cleared by one");
    $display("test sense modes done");
    apb(1'b0, `OFF_EVT_STATUS, 32'h0);
    ext_irq_pin <= 1'b0;
    tick(4);
    ext_irq_pin <= 1'b1;
    tick(4);
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(`OFF_EVT_MASK, 32'h1);
    chk("unmasked irq", 32'h1, {31'h0, irq});
    rdchk(`OFF_EVT_STATUS, 32'h1, "event status");
    chk("irq after read", 32'h0, {31'h0, irq});
    wr(`OFF_EVT_MASK, 32'h0);
    $display("test interrupt output done");
    slow <= 1'b1;
    wr(`OFF_SENSE, 32'h2);
    wr(`OFF_EXT_EN, 32'h1);
    ext_irq_pin <= 1'b0;
    tick(5);
    chk("no vector without global", 32'h0, {31'h0, core_req.valid});
    global_irq_enable <= 1'b1;
    wait_ack(16'h0001);
    tick(2);
    rdchk(`OFF_EXT_FLAGS, 32'h0, "flag cleared by vector");
    ext_irq_pin <= 1'b1;
    global_irq_enable <= 1'b0;
    wr(`OFF_EXT_EN, 32'h0);
    $display("test pin vector done");
    wr(`OFF_PC_MASK, 32'h5);
    wr(`OFF_PC_CTRL, 32'h1);
    pin_change_inputs[1] <= 1'b1;
    tick(4);
    rdchk(`OFF_PC_FLAGS, 32'h0, "masked-out pin");
    pin_change_inputs[0] <= 1'b1;
    tick(1);
    chk("wake on change", 32'h1, {31'h0, wake_req});
    tick(3);
    rdchk(`OFF_PC_FLAGS, 32'h1, "change flag");
    wr(`OFF_PC_FLAGS, 32'h1);
    rdchk(`OFF_PC_FLAGS, 32'h0, "change flag cleared");
    global_irq_enable <= 1'b1;
    pin_change_inputs[0] <= 1'b0;
    wait_ack(16'h0002);
    tick(2);
    rdchk(`OFF_PC_FLAGS, 32'h0, "change flag after vector");
    global_irq_enable <= 1'b0;
    wr(`OFF_PC_CTRL, 32'h0);
    $display("test pin change done");
    slow <= 1'b0;
    wr(`OFF_SENSE, 32'h0);
    wr(`OFF_EXT_EN, 32'h1);
    global_irq_enable <= 1'b1;
    ext_irq_pin <= 1'b0;
    tick(1);
    chk("wake on low", 32'h1, {31'h0, wake_req});
    wait_ack(16'h0001);
    wait_ack(16'h0001);
    ext_irq_pin <= 1'b1;
    tick(8);
    chk("level released", 32'h0, {31'h0, core_req.valid});
    global_irq_enable <= 1'b0;
    $display("test level mode done");
    slow <= 1'b1;
    global_irq_enable <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      other_irq_req <= 8'h01 << i;
      wait_ack(16'(3 + i));
      other_irq_req <= 8'h00;
      tick(6);
    end
    global_irq_enable <= 1'b0;
    wr(`OFF_SENSE, 32'h2);
    other_irq_req <= 8'h80;
    ext_irq_pin <= 1'b0;
    tick(5);
    global_irq_enable <= 1'b1;
    wait_ack(16'h0001);
    wait_ack(16'h000a);
    other_irq_req <= 8'h00;
    global_irq_enable <= 1'b0;
    ext_irq_pin <= 1'b1;
    tick(4);
    $display("test priority done");
    tally_and_finish();
  end
endmodule

// [src/external_irq_and_vector_unit.sv]
// external pin and pin-change interrupt detection with vector selection
// assumes one clock pclk, apb register access, core acks vectors on pclk
//
// Added by the designer: the register addresses and the APB register port.
`include "irq_vec_params.svh"

// Behaviour
// - ten sources map to addresses one to ten
// - every reset starts at address zero
// - pins trigger even when driven as outputs
// - any masked monitored pin change requests
// - pin-change wake works without clock
// - two-bit sense: low, change, fall, rise
// - low level requests while pin low
// - edges clocked, low level wakes asynchronously
// - vanished low level gives no interrupt; here the sticky event status stays set and drives irq when unmasked
// - pin sampled; longer-than-clock pulses caught
// - pin interrupt needs enable and global enable
// - edge sets flag; vectoring or one clears
// - pin flag reads zero in level mode
// - pin-change needs group and global enable
// - change sets flag; vectoring or one clears
// - four mask bits select monitored pins
// - unused upper register bits read zero
module external_irq_and_vector_unit #(
  parameter int NUM_PC = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic ext_irq_pin,
  input wire logic [NUM_PC-1:0] pin_change_inputs,
  // other sources: capture, overflow, match a, match b, comparator, watchdog, supply, converter
  input wire logic [7:0] other_irq_req,
  // processor core
  input wire logic global_irq_enable,
  input wire logic vector_ack,
  output irq_vec_pkg::vec_req_t core_req,
  output logic boot_fetch,
  output logic wake_req,
  output logic irq
);

  logic [1:0] ext_sync_q;
  logic ext_prev_q;
  logic [NUM_PC-1:0] pc_sync1_q;
  logic [NUM_PC-1:0] pc_sync2_q;
  logic [NUM_PC-1:0] pc_prev_q;
  irq_vec_pkg::sense_t sense_q;
  logic ext_en_q;
  logic ext_flag_q;
  logic pin_change_group_enable;
  logic pin_change_flag;
  logic [NUM_PC-1:0] pc_mask_q;
  logic [1:0] evt_status_q;
  logic [1:0] evt_mask_q;
  logic boot_q;
  irq_vec_pkg::vec_req_t req_q;
  irq_vec_pkg::apb_req_t bus;

  logic ext_now;
  logic ext_trig;
  logic [NUM_PC-1:0] pc_change;
  logic pc_trig;
  logic ext_level_req;
  logic [`NUM_SOURCES-1:0] src_req;
  logic wr;
  logic rd;
  logic ack_ext;
  logic ack_pc;

  // lowest set index gives the lowest vector address
  function automatic logic [15:0] pick_vector(input logic [`NUM_SOURCES-1:0] req);
    logic [15:0] v;
    v = `VEC_RESET;
    for (int i = `NUM_SOURCES - 1; i >= 0; i--) begin
      if (req[i]) begin
        v = `VEC_FIRST + 16'(i);
      end
    end
    return v;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign bus = '{psel, penable, pwrite, paddr, pwdata};
  assign wr = bus.sel && bus.enable && bus.write;
  assign rd = bus.sel && bus.enable && !bus.write;
  assign pready = 1'b1;

  // pad levels are sampled regardless of pin direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync_q <= 2'h3;
      ext_prev_q <= 1'b1;
    end else begin
      ext_sync_q <= {ext_sync_q[0], ext_irq_pin};
      ext_prev_q <= ext_sync_q[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_sync1_q <= '0;
      pc_sync2_q <= '0;
      pc_prev_q <= '0;
    end else begin
      pc_sync1_q <= pin_change_inputs;
      pc_sync2_q <= pc_sync1_q;
      pc_prev_q <= pc_sync2_q;
    end
  end

  assign ext_now = ext_sync_q[1];

  // edge and change detection on the synchronised pin
  always_comb begin
    case (sense_q)
      irq_vec_pkg::SENSE_CHANGE: ext_trig = ext_now ^ ext_prev_q;
      irq_vec_pkg::SENSE_FALL: ext_trig = ext_prev_q && !ext_now;
      irq_vec_pkg::SENSE_RISE: ext_trig = !ext_prev_q && ext_now;
      default: ext_trig = 1'b0;
    endcase
  end

  // level request follows the pin; a vanished level leaves only the sticky event status bit set
  assign ext_level_req = (sense_q == irq_vec_pkg::SENSE_LOW) && ext_en_q && !ext_now;

  assign pc_change = (pc_sync2_q ^ pc_prev_q) & pc_mask_q;
  assign pc_trig = |pc_change;

  // unclocked wake path for sleep with the clock stopped
  assign wake_req = (ext_en_q && sense_q == irq_vec_pkg::SENSE_LOW && !ext_irq_pin)
    || (pin_change_group_enable && |((pin_change_inputs ^ pc_prev_q) & pc_mask_q));

  assign ack_ext = vector_ack && req_q.valid && req_q.addr == `VEC_FIRST + 16'(`SRC_EXT);
  assign ack_pc = vector_ack && req_q.valid && req_q.addr == `VEC_FIRST + 16'(`SRC_PC);

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_q <= irq_vec_pkg::sense_t'(`RST_SENSE);
      ext_en_q <= `RST_EN;
      pin_change_group_enable <= `RST_EN;
      pc_mask_q <= `RST_PC_MASK;
      evt_mask_q <= `RST_EVT;
    end else if (wr) begin
      if (hit(bus.addr, `OFF_SENSE)) begin
        sense_q <= irq_vec_pkg::sense_t'(bus.wdata[1:0]);
      end
      if (hit(bus.addr, `OFF_EXT_EN)) begin
        ext_en_q <= bus.wdata[0];
      end
      if (hit(bus.addr, `OFF_PC_CTRL)) begin
        pin_change_group_enable <= bus.wdata[0];
      end
      if (hit(bus.addr, `OFF_PC_MASK)) begin
        pc_mask_q <= bus.wdata[NUM_PC-1:0];
      end
      if (hit(bus.addr, `OFF_EVT_MASK)) begin
        evt_mask_q <= bus.wdata[1:0];
      end
    end
  end

  // external flag: set wins over either clear, held zero in level mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_flag_q <= 1'b0;
    end else if (sense_q == irq_vec_pkg::SENSE_LOW) begin
      ext_flag_q <= 1'b0;
    end else if (ext_trig) begin
      ext_flag_q <= 1'b1;
    end else if (ack_ext || (wr && hit(bus.addr, `OFF_EXT_FLAGS) && bus.wdata[0])) begin
      ext_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_change_flag <= 1'b0;
    end else if (pc_trig) begin
      pin_change_flag <= 1'b1;
    end else if (ack_pc || (wr && hit(bus.addr, `OFF_PC_FLAGS) && bus.wdata[0])) begin
      pin_change_flag <= 1'b0;
    end
  end

  // sticky event status, cleared by reading it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status_q <= `RST_EVT;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == `EVT_EXT && (ext_trig || ext_level_req)) || (i == `EVT_PC && pc_trig)) begin
          evt_status_q[i] <= 1'b1;
        end else if (rd && hit(bus.addr, `OFF_EVT_STATUS)) begin
          evt_status_q[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(evt_status_q & evt_mask_q);

  // enabled requests in vector order
  always_comb begin
    src_req = '0;
    src_req[`SRC_EXT] = ext_en_q && (ext_flag_q || ext_level_req);
    src_req[`SRC_PC] = pin_change_group_enable && pin_change_flag;
    src_req[`NUM_SOURCES-1:2] = other_irq_req;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= '{1'b0, `VEC_RESET};
    end else if (ack_ext || ack_pc || vector_ack) begin
      req_q <= '{1'b0, `VEC_RESET};
    end else begin
      req_q.valid <= global_irq_enable && |src_req;
      req_q.addr <= global_irq_enable ? pick_vector(src_req) : `VEC_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  assign core_req = req_q;
  assign boot_fetch = boot_q;

  // read mux; reserved bits stay zero
  always_comb begin
    prdata = '0;
    pslverr = 1'b0;
    if (bus.sel && bus.enable) begin
      case (bus.addr)
        `OFF_SENSE: prdata[1:0] = sense_q;
        `OFF_EXT_EN: prdata[0] = ext_en_q;
        `OFF_EXT_FLAGS: prdata[0] = ext_flag_q;
        `OFF_PC_CTRL: prdata[0] = pin_change_group_enable;
        `OFF_PC_FLAGS: prdata[0] = pin_change_flag;
        `OFF_PC_MASK: prdata[NUM_PC-1:0] = pc_mask_q;
        `OFF_EVT_STATUS: prdata[1:0] = evt_status_q;
        `OFF_EVT_MASK: prdata[1:0] = evt_mask_q;
        default: pslverr = 1'b1;
      endcase
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_vec_range;
    core_req.valid |-> core_req.addr >= `VEC_FIRST && core_req.addr <= `VEC_LAST;
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("vector outside table");

  property p_boot_zero;
    boot_fetch |-> core_req.addr == `VEC_RESET && !core_req.valid;
  endproperty
  a_boot_zero: assert property (p_boot_zero) else $error("boot not at zero");

  property p_fall_sets;
    sense_q == irq_vec_pkg::SENSE_FALL && ext_prev_q && !ext_now |=> ext_flag_q;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost");

  property p_level_req;
    ext_level_req && global_irq_enable && !vector_ack |=> core_req.valid && core_req.addr == `VEC_FIRST;
  endproperty
  a_level_req: assert property (p_level_req) else $error("low level not requested");

  property p_no_gie;
    !global_irq_enable |=> !core_req.valid;
  endproperty
  a_no_gie: assert property (p_no_gie) else $error("request without global enable");

  property p_flag_w1c;
    wr && hit(bus.addr, `OFF_EXT_FLAGS) && bus.wdata[0] && !ext_trig |=> !ext_flag_q;
  endproperty
  a_flag_w1c: assert property (p_flag_w1c) else $error("flag not cleared by one");

  property p_level_flag_zero;
    sense_q == irq_vec_pkg::SENSE_LOW |=> !ext_flag_q || sense_q != irq_vec_pkg::SENSE_LOW;
  endproperty
  a_level_flag_zero: assert property (p_level_flag_zero) else $error("flag set in level mode");

  property p_pc_sets;
    (pc_sync2_q[0] != pc_prev_q[0]) && pc_mask_q[0] |=> pin_change_flag;
  endproperty
  a_pc_sets: assert property (p_pc_sets) else $error("pin change lost");

  property p_mask_blocks;
    pc_mask_q == '0 && !pin_change_flag ##1 pc_mask_q == '0 |-> !pin_change_flag;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked pin set flag");

  property p_priority;
    global_irq_enable && src_req[`SRC_EXT] && !vector_ack |=> core_req.addr == `VEC_FIRST;
  endproperty
  a_priority: assert property (p_priority) else $error("lower vector not first");

  property p_reserved;
    rd && hit(bus.addr, `OFF_SENSE) |-> prdata[31:2] == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_ack_clears_ext;
    ack_ext && !ext_trig |=> !ext_flag_q;
  endproperty
  a_ack_clears_ext: assert property (p_ack_clears_ext) else $error("pin flag kept after vector");

  property p_ack_clears_pc;
    ack_pc && !pc_trig |=> !pin_change_flag;
  endproperty
  a_ack_clears_pc: assert property (p_ack_clears_pc) else $error("change flag kept after vector");

  property p_pc_vec;
    global_irq_enable && src_req[`SRC_PC] && !src_req[`SRC_EXT] && !vector_ack
      |=> core_req.valid && core_req.addr == `VEC_FIRST + 16'(`SRC_PC);
  endproperty
  a_pc_vec: assert property (p_pc_vec) else $error("pin change not vectored");

  c_fall: cover property (sense_q == irq_vec_pkg::SENSE_FALL && ext_trig ##1 ext_flag_q);
  c_pc: cover property (pc_trig ##1 pin_change_flag ##[1:4] ack_pc);
  c_irq: cover property (irq ##[1:4] !irq);
  c_level: cover property (ext_level_req ##1 core_req.valid ##[1:4] vector_ack);
  c_two_pending: cover property (src_req[`SRC_EXT] && src_req[`NUM_SOURCES-1] && core_req.valid);

endmodule

// [src/irq_vec_params.svh]
// offsets, reset values, vectors and field positions of the interrupt unit
// assumes a 32-bit apb slave with word-aligned registers
`ifndef IRQ_VEC_PARAMS_SVH
`define IRQ_VEC_PARAMS_SVH

`define OFF_SENSE 8'h00
`define OFF_EXT_EN 8'h04
`define OFF_EXT_FLAGS 8'h08
`define OFF_PC_CTRL 8'h0c
`define OFF_PC_FLAGS 8'h10
`define OFF_PC_MASK 8'h14
`define OFF_EVT_STATUS 8'h18
`define OFF_EVT_MASK 8'h1c

`define RST_SENSE 2'h0
`define RST_EN 1'h0
`define RST_PC_MASK 4'h0
`define RST_EVT 2'h0

`define VEC_RESET 16'h0000
`define VEC_FIRST 16'h0001
`define VEC_LAST 16'h000a
`define NUM_SOURCES 10

`define SRC_EXT 0
`define SRC_PC 1
`define EVT_EXT 0
`define EVT_PC 1

`endif

// [src/irq_vec_pkg.sv]
// types of the interrupt and vector unit
// assumes irq_vec_params.svh supplies the numbers
package irq_vec_pkg;

  typedef enum logic [1:0] {
    SENSE_LOW,
    SENSE_CHANGE,
    SENSE_FALL,
    SENSE_RISE
  } sense_t;

  // request towards the processor core
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } vec_req_t;

  // apb request fields
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

endpackage
